//--- hdl/urd_regs.svh
`ifndef URD_REGS_SVH
`define URD_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices. The byte address on the bus is four times the index.
`define URD_IDX_SHARED0 16'h9C00
`define URD_IDX_SHARED1 16'h9C01
`define URD_IDX_SHARED2 16'h9C02
`define URD_IDX_LCR 16'h9C03
`define URD_IDX_MCR 16'h9C04
`define URD_IDX_LSR 16'h9C05
`define URD_IDX_SCR 16'h9C07
`define URD_IDX_DLL 16'h9C08
`define URD_IDX_DLM 16'h9C09
`define URD_IDX_PID_LO 16'h9C0A
`define URD_IDX_PID_HI 16'h9C0B
`define URD_IDX_PECR 16'h9C0C

////////////////////////////////////////////////////////////////////////////////
// Address field positions within the bus byte address.
`define URD_ADR_IDX_LSB 2
`define URD_ADR_IDX_MSB 17
`define URD_ADR_TOP_LSB 18

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define URD_LCR_DIV_SEL_BIT 7

////////////////////////////////////////////////////////////////////////////////
// Reset values held by this block.
`define URD_IER_RST 8'h00
`define URD_LCR_RST 8'h00
`define URD_MCR_RST 8'h00
`define URD_SCR_RST 8'h00
`define URD_DLL_RST 8'h00
`define URD_DLM_RST 8'h00
`define URD_PECR_RST 16'h0000
`define URD_RDATA_RST 32'h0000_0000

// Reset values that the serial core presents on its status lines.
`define URD_IIR_CORE_RST 8'h01
`define URD_LSR_CORE_RST 8'h60

// Identification defaults; the values are arbitrary.
`define URD_PID_LO_DEF 16'h00A5
`define URD_PID_HI_DEF 16'h5A00

`endif

//--- hdl/urd_pkg.sv
package urd_pkg;

    typedef enum logic [3:0] {
        URD_TGT_NONE = 4'h0,
        URD_TGT_DATA = 4'h1,
        URD_TGT_DLL = 4'h2,
        URD_TGT_IER = 4'h3,
        URD_TGT_DLM = 4'h4,
        URD_TGT_IIR_FCR = 4'h5,
        URD_TGT_LCR = 4'h6,
        URD_TGT_MCR = 4'h7,
        URD_TGT_LSR = 4'h8,
        URD_TGT_SCR = 4'h9,
        URD_TGT_PID_LO = 4'hA,
        URD_TGT_PID_HI = 4'hB,
        URD_TGT_PECR = 4'hC
    } urd_tgt_t;

    typedef enum logic [1:0] {
        URD_ACK_IDLE = 2'b01,
        URD_ACK_BUSY = 2'b10
    } urd_ack_state_t;

    typedef struct packed {
        logic [15:0] power_emulation_control;
        logic [7:0] scratch_reg;
        logic [7:0] modem_control;
        logic [7:0] line_control;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] divisor_high_byte;
        logic [7:0] divisor_low_byte;
    } urd_ctrl_t;

    typedef struct packed {
        logic [7:0] receive_buffer;
        logic [7:0] interrupt_ident;
        logic [7:0] line_status;
    } urd_status_t;

    typedef struct packed {
        logic [7:0] transmit_holding;
        logic tx_load;
        logic [7:0] fifo_control;
        logic fifo_load;
        logic rx_pop;
    } urd_strobe_t;

    typedef struct packed {
        urd_ctrl_t ctrl;
        urd_strobe_t strb;
        urd_tgt_t tgt;
        logic [31:0] rdata;
    } urd_top_state_t;

    typedef struct packed {
        urd_ack_state_t state;
    } urd_ack_reg_t;

endpackage

//--- hdl/urd_ack.sv
module urd_ack (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic REQ,
    output logic START,
    output logic DONE,
    output logic ACK
);
    import urd_pkg::*;

    urd_ack_reg_t st_ff;
    urd_ack_reg_t nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // One wait state: the request is taken, the answer follows one edge later.
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff.state)
            URD_ACK_IDLE:
            begin
                if (REQ)
                    nxt_st.state = URD_ACK_BUSY;
            end
            URD_ACK_BUSY:
            begin
                nxt_st.state = URD_ACK_IDLE;
            end
            default:
            begin
                nxt_st.state = URD_ACK_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            st_ff <= '{state: URD_ACK_IDLE};
        else
            st_ff <= nxt_st;
    end

    assign ACK = (st_ff.state == URD_ACK_BUSY);
    assign START = REQ && (st_ff.state == URD_ACK_IDLE);
    assign DONE = REQ && (st_ff.state == URD_ACK_BUSY);
endmodule

//--- hdl/urd_rdmux.sv
module urd_rdmux (
    input urd_pkg::urd_tgt_t TGT,
    input urd_pkg::urd_ctrl_t CTRL,
    input urd_pkg::urd_status_t STATUS,
    input wire logic [15:0] PID_LO,
    input wire logic [15:0] PID_HI,
    output logic [31:0] RDATA
);
    import urd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Narrow registers sit in the low bits; everything above reads as zero.
    always_comb
    begin
        RDATA = 32'h0000_0000;
        case (TGT)
            URD_TGT_DATA: RDATA[7:0] = STATUS.receive_buffer;
            URD_TGT_DLL: RDATA[7:0] = CTRL.divisor_low_byte;
            URD_TGT_IER: RDATA[7:0] = CTRL.interrupt_enable_reg;
            URD_TGT_DLM: RDATA[7:0] = CTRL.divisor_high_byte;
            URD_TGT_IIR_FCR: RDATA[7:0] = STATUS.interrupt_ident;
            URD_TGT_LCR: RDATA[7:0] = CTRL.line_control;
            URD_TGT_MCR: RDATA[7:0] = CTRL.modem_control;
            URD_TGT_LSR: RDATA[7:0] = STATUS.line_status;
            URD_TGT_SCR: RDATA[7:0] = CTRL.scratch_reg;
            URD_TGT_PID_LO: RDATA[15:0] = PID_LO;
            URD_TGT_PID_HI: RDATA[15:0] = PID_HI;
            URD_TGT_PECR: RDATA[15:0] = CTRL.power_emulation_control;
            default: RDATA = 32'h0000_0000;
        endcase
    end
endmodule

//--- hdl/urd_top.sv
// The Wishbone register port was chosen for this implementation.
`include "urd_regs.svh"

// Notes on behaviour
// R1: Select bit clear: reading word 0 gives receive buffer, writing loads transmit holding.
// R2: Select bit set: word 0 reads and writes the divisor low byte.
// R3: Select bit clear: word 1 reads and writes the interrupt enable register.
// R4: Select bit set: word 1 reads and writes the divisor high byte.
// R5: Word 2 reads interrupt identification and writes FIFO control.
// R6: Divisor low byte also has its own address, regardless of the select bit.
// R7: Divisor high byte also has its own address, regardless of the select bit.
// R8: Select bit lives in line control bit 7, effective on the very next access.
module urd_top #(
    parameter logic [15:0] PID_LO_VALUE = `URD_PID_LO_DEF,
    parameter logic [15:0] PID_HI_VALUE = `URD_PID_HI_DEF
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input urd_pkg::urd_status_t CORE_STATUS,
    output urd_pkg::urd_ctrl_t CORE_CTRL,
    output urd_pkg::urd_strobe_t CORE_STROBE
);
    import urd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    urd_top_state_t st_ff;
    urd_top_state_t nxt_st;
    logic req;
    logic start;
    logic done;
    logic ack;
    logic in_window;
    logic [15:0] idx;
    logic div_sel;
    urd_tgt_t dec_tgt;
    logic [31:0] mux_rdata;
    logic [1:0] lane_en;
    logic [1:0][7:0] lane_dat;
    logic wr_commit;
    logic rd_commit;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake. The request is taken on the first edge that sees cyc and
    // stb, ack rises after that edge, and the write commits on the edge that
    // the master samples ack. Ack drops in the following cycle.
    assign req = WB_CYC_I && WB_STB_I;

    urd_ack u_ack (
        .SYS_CLK(SYS_CLK),
        .RESETN(RESETN),
        .REQ(req),
        .START(start),
        .DONE(done),
        .ACK(ack)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    assign idx = WB_ADR_I[`URD_ADR_IDX_MSB:`URD_ADR_IDX_LSB];
    assign in_window = (WB_ADR_I[31:`URD_ADR_TOP_LSB] == 14'h0000);
    assign div_sel = st_ff.ctrl.line_control[`URD_LCR_DIV_SEL_BIT]; // R8

    ////////////////////////////////////////////////////////////////////////////
    // Byte lanes. Only the two low lanes carry register bits; a lane whose
    // select is low leaves its byte untouched, so a narrow write never
    // disturbs the other half of the wide power control register.
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_lane
            assign lane_en[g] = WB_SEL_I[g];
            assign lane_dat[g] = WB_DAT_I[8 * g +: 8];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Commit qualifiers. Both fire only on the edge at which the master
    // samples ack, so a request that is dropped early changes nothing.
    assign wr_commit = done && WB_WE_I;
    assign rd_commit = done && !WB_WE_I;

    // The select bit is read from the committed register, so a write to
    // line control steers the next access and never the one in flight.
    always_comb
    begin
        dec_tgt = URD_TGT_NONE;
        if (in_window)
        begin
            case (idx)
                // Shared words, steered by the select bit.
                `URD_IDX_SHARED0:
                begin
                    if (div_sel)
                    begin
                        dec_tgt = URD_TGT_DLL; // R2
                    end
                    else
                    begin
                        dec_tgt = URD_TGT_DATA; // R1
                    end
                end
                `URD_IDX_SHARED1:
                begin
                    if (div_sel)
                    begin
                        dec_tgt = URD_TGT_DLM; // R4
                    end
                    else
                    begin
                        dec_tgt = URD_TGT_IER; // R3
                    end
                end
                // Direction-steered word: the access direction picks the register.
                `URD_IDX_SHARED2:
                begin
                    dec_tgt = URD_TGT_IIR_FCR; // R5
                end
                // Plain control and status words.
                `URD_IDX_LCR:
                begin
                    dec_tgt = URD_TGT_LCR;
                end
                `URD_IDX_MCR:
                begin
                    dec_tgt = URD_TGT_MCR;
                end
                `URD_IDX_LSR:
                begin
                    dec_tgt = URD_TGT_LSR;
                end
                `URD_IDX_SCR:
                begin
                    dec_tgt = URD_TGT_SCR;
                end
                // Direct divisor aliases, blind to the select bit.
                `URD_IDX_DLL:
                begin
                    dec_tgt = URD_TGT_DLL; // R6
                end
                `URD_IDX_DLM:
                begin
                    dec_tgt = URD_TGT_DLM; // R7
                end
                // Identification and power control.
                `URD_IDX_PID_LO:
                begin
                    dec_tgt = URD_TGT_PID_LO;
                end
                `URD_IDX_PID_HI:
                begin
                    dec_tgt = URD_TGT_PID_HI;
                end
                `URD_IDX_PECR:
                begin
                    dec_tgt = URD_TGT_PECR;
                end
                default:
                begin
                    dec_tgt = URD_TGT_NONE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data selection.
    urd_rdmux u_rdmux (
        .TGT(dec_tgt),
        .CTRL(st_ff.ctrl),
        .STATUS(CORE_STATUS),
        .PID_LO(PID_LO_VALUE),
        .PID_HI(PID_HI_VALUE),
        .RDATA(mux_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb
    begin
        nxt_st = st_ff;
        // Strobes are single-cycle pulses: cleared here, raised only on commit.
        nxt_st.strb.tx_load = 1'b0;
        nxt_st.strb.fifo_load = 1'b0;
        nxt_st.strb.rx_pop = 1'b0;

        // The decode is frozen when the request is taken, so the commit edge
        // acts on the same target that the read data were taken from.
        if (start)
        begin
            nxt_st.tgt = dec_tgt;
            if (WB_WE_I)
            begin
                nxt_st.rdata = 32'h0000_0000;
            end
            else
            begin
                nxt_st.rdata = mux_rdata;
            end
        end

        if (rd_commit)
        begin
            // Reading the receive buffer consumes the byte, once per access.
            if (st_ff.tgt == URD_TGT_DATA)
            begin
                nxt_st.strb.rx_pop = 1'b1; // R1
            end
        end

        if (wr_commit)
        begin
            case (st_ff.tgt)
                // Transmit holding is handed to the core with a pulse; this
                // block keeps only the last byte for it.
                URD_TGT_DATA:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.strb.transmit_holding = lane_dat[0]; // R1
                        nxt_st.strb.tx_load = 1'b1; // R1
                    end
                end
                // The shared word and the direct alias reach the same divisor
                // flip-flops, so the two views can never disagree.
                URD_TGT_DLL:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.ctrl.divisor_low_byte = lane_dat[0]; // R2
                    end
                end
                URD_TGT_IER:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.ctrl.interrupt_enable_reg = lane_dat[0]; // R3
                    end
                end
                URD_TGT_DLM:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.ctrl.divisor_high_byte = lane_dat[0]; // R4
                    end
                end
                URD_TGT_IIR_FCR:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.strb.fifo_control = lane_dat[0]; // R5
                        nxt_st.strb.fifo_load = 1'b1; // R5
                    end
                end
                // A new select bit steers the next access, never this one.
                URD_TGT_LCR:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.ctrl.line_control = lane_dat[0]; // R8
                    end
                end
                URD_TGT_MCR:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.ctrl.modem_control = lane_dat[0];
                    end
                end
                URD_TGT_SCR:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.ctrl.scratch_reg = lane_dat[0];
                    end
                end
                URD_TGT_PECR:
                begin
                    if (lane_en[0])
                    begin
                        nxt_st.ctrl.power_emulation_control[7:0] = lane_dat[0];
                    end
                    if (lane_en[1])
                    begin
                        nxt_st.ctrl.power_emulation_control[15:8] = lane_dat[1];
                    end
                end
                URD_TGT_LSR, URD_TGT_PID_LO, URD_TGT_PID_HI:
                begin
                    // Status and identification are read-only: the write is
                    // acknowledged and dropped.
                    nxt_st.ctrl = st_ff.ctrl;
                end
                default:
                begin
                    // Unmapped words ignore writes.
                    nxt_st.ctrl = st_ff.ctrl;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            // Control registers seen by the core.
            st_ff.ctrl.power_emulation_control <= `URD_PECR_RST;
            st_ff.ctrl.scratch_reg <= `URD_SCR_RST;
            st_ff.ctrl.modem_control <= `URD_MCR_RST;
            st_ff.ctrl.line_control <= `URD_LCR_RST;
            st_ff.ctrl.interrupt_enable_reg <= `URD_IER_RST;
            st_ff.ctrl.divisor_high_byte <= `URD_DLM_RST;
            st_ff.ctrl.divisor_low_byte <= `URD_DLL_RST;
            // Strobes and bus-side state.
            st_ff.strb.transmit_holding <= 8'h00;
            st_ff.strb.tx_load <= 1'b0;
            st_ff.strb.fifo_control <= 8'h00;
            st_ff.strb.fifo_load <= 1'b0;
            st_ff.strb.rx_pop <= 1'b0;
            st_ff.tgt <= URD_TGT_NONE;
            st_ff.rdata <= `URD_RDATA_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign WB_ACK_O = ack;
    // Read data come from a register, so they stand for as long as ack does.
    assign WB_DAT_O = st_ff.rdata;
    assign CORE_CTRL = st_ff.ctrl;
    assign CORE_STROBE = st_ff.strb;
endmodule

//--- verif/urd_assertions.sv
module urd_checker (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input urd_pkg::urd_status_t CORE_STATUS,
    input urd_pkg::urd_ctrl_t CORE_CTRL,
    input urd_pkg::urd_strobe_t CORE_STROBE
);
    import urd_pkg::*;

    wire logic take;
    wire logic div_sel;
    wire logic [15:0] idx;
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O && (WB_ADR_I[31:18] == 14'h0);
    assign div_sel = CORE_CTRL.line_control[7];
    assign idx = WB_ADR_I[17:2];

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_wr(logic [15:0] w, logic d);
        take && WB_WE_I && WB_SEL_I[0] && idx == w && div_sel == d;
    endsequence
    sequence s_rd(logic [15:0] w, logic d);
        take && !WB_WE_I && idx == w && div_sel == d;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    chk_ack_one_pulse: assert property (take |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not one cycle after request");
    chk_rx_read_pop: assert property (s_rd(16'h9C00, 1'b0) |=> WB_ACK_O &&
        WB_DAT_O[7:0] == $past(CORE_STATUS.receive_buffer) ##1 CORE_STROBE.rx_pop)
        else $error("receive buffer read wrong");
    chk_tx_write_load: assert property (s_wr(16'h9C00, 1'b0) |-> ##2 CORE_STROBE.tx_load &&
        CORE_STROBE.transmit_holding == $past(WB_DAT_I[7:0], 2))
        else $error("transmit load wrong");
    chk_dll_shared_wr: assert property (s_wr(16'h9C00, 1'b1) |-> ##2 !CORE_STROBE.tx_load &&
        CORE_CTRL.divisor_low_byte == $past(WB_DAT_I[7:0], 2))
        else $error("shared divisor low write wrong");
    chk_ier_shared_wr: assert property (s_wr(16'h9C01, 1'b0) |-> ##2
        CORE_CTRL.interrupt_enable_reg == $past(WB_DAT_I[7:0], 2))
        else $error("interrupt enable write wrong");
    chk_dlm_shared_rd: assert property (s_rd(16'h9C01, 1'b1) |=>
        WB_DAT_O[7:0] == $past(CORE_CTRL.divisor_high_byte))
        else $error("shared divisor high read wrong");
    chk_ident_read: assert property (s_rd(16'h9C02, div_sel) |=>
        WB_DAT_O[7:0] == $past(CORE_STATUS.interrupt_ident))
        else $error("identification read wrong");
    chk_fifo_ctrl_wr: assert property (s_wr(16'h9C02, div_sel) |-> ##2
        CORE_STROBE.fifo_load && CORE_STROBE.fifo_control == $past(WB_DAT_I[7:0], 2))
        else $error("fifo control write wrong");
    chk_dll_alias_wr: assert property (s_wr(16'h9C08, div_sel) |-> ##2
        CORE_CTRL.divisor_low_byte == $past(WB_DAT_I[7:0], 2))
        else $error("direct divisor low write wrong");
    chk_dlm_alias_rd: assert property (s_rd(16'h9C09, div_sel) |=>
        WB_DAT_O[7:0] == $past(CORE_CTRL.divisor_high_byte))
        else $error("direct divisor high read wrong");
    chk_lcr_write: assert property (s_wr(16'h9C03, div_sel) |-> ##2
        CORE_CTRL.line_control == $past(WB_DAT_I[7:0], 2))
        else $error("line control write wrong");
endmodule

bind urd_top urd_checker u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .CORE_STATUS(CORE_STATUS), .CORE_CTRL(CORE_CTRL), .CORE_STROBE(CORE_STROBE));

//--- verif/urd_tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import urd_pkg::*;

    // Identification values are arbitrary.
    localparam logic [15:0] pid_lo = 16'h1E2D;
    localparam logic [15:0] pid_hi = 16'h3C4B;
    logic sys_clk, resetn, cyc, stb, we, ack;
    logic [31:0] adr, wdat, rdat, rd;
    logic [3:0] sel;
    urd_status_t status;
    urd_ctrl_t ctrl;
    urd_strobe_t strb;
    int n_errors = 0;
    int checked = 0;
    int n_tx = 0;
    int n_ff = 0;
    int n_pop = 0;

    urd_top #(.PID_LO_VALUE(pid_lo), .PID_HI_VALUE(pid_hi)) dut (.SYS_CLK(sys_clk),
        .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CORE_STATUS(status), .CORE_CTRL(ctrl), .CORE_STROBE(strb));

    always #20 sys_clk = ~sys_clk;

    // Strobes are counted mid-cycle so the count never races the bus tasks.
    always @(negedge sys_clk)
    begin
        if (strb.tx_load === 1'b1) n_tx++;
        if (strb.fifo_load === 1'b1) n_ff++;
        if (strb.rx_pop === 1'b1) n_pop++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w_en, input logic [15:0] w, input logic [31:0] d,
        input logic [3:0] s = 4'hF);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_en;
        adr <= {14'h0, w, 2'h0};
        sel <= s;
        wdat <= d;
        i = 0;
        do
        begin
            @(posedge sys_clk);
            i++;
        end
        while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1)
        begin
            n_errors++;
            wrap_up();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdx(input logic [15:0] w, input logic [31:0] exp);
        wb(1'b0, w, 32'h0);
        chk(rd, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdx(16'h9C01, 32'h0);
        rdx(16'h9C02, 32'h01);
        rdx(16'h9C03, 32'h0);
        rdx(16'h9C04, 32'h0);
        rdx(16'h9C05, 32'h60);
        rdx(16'h9C0C, 32'h0);
    endtask

    task automatic t_data();
        int p, t, f;
        p = n_pop;
        t = n_tx;
        f = n_ff;
        status <= {8'hA7, 8'hC4, 8'h61};
        rdx(16'h9C00, 32'hA7);
        chk(32'(n_pop - p), 32'h1);
        wb(1'b1, 16'h9C00, 32'h5A);
        chk(32'(n_tx - t), 32'h1);
        chk(32'(strb.transmit_holding), 32'h5A);
        chk(32'(ctrl.divisor_low_byte), 32'h0);
        rdx(16'h9C02, 32'hC4);
        wb(1'b1, 16'h9C02, 32'h87);
        chk(32'(strb.fifo_control), 32'h87);
        chk(32'(n_ff - f), 32'h1);
        rdx(16'h9C02, 32'hC4);
        wb(1'b1, 16'h9C05, 32'hFF);
        rdx(16'h9C05, 32'h61);
    endtask

    task automatic t_divisor_access_select();
        int p, t;
        p = n_pop;
        t = n_tx;
        wb(1'b1, 16'h9C03, 32'h83);
        chk(32'(ctrl.line_control), 32'h83);
        wb(1'b1, 16'h9C00, 32'h34);
        chk(32'(ctrl.divisor_low_byte), 32'h34);
        wb(1'b1, 16'h9C01, 32'h12);
        chk(32'(ctrl.divisor_high_byte), 32'h12);
        chk(32'(ctrl.interrupt_enable_reg), 32'h0);
        rdx(16'h9C00, 32'h34);
        rdx(16'h9C01, 32'h12);
        chk(32'(n_tx - t + n_pop - p), 32'h0);
        wb(1'b1, 16'h9C03, 32'h03);
        wb(1'b1, 16'h9C01, 32'h0F);
        rdx(16'h9C01, 32'h0F);
        chk(32'(ctrl.divisor_high_byte), 32'h12);
    endtask

    task automatic t_alias();
        wb(1'b1, 16'h9C08, 32'h77);
        rdx(16'h9C08, 32'h77);
        wb(1'b1, 16'h9C09, 32'h66);
        rdx(16'h9C01, 32'h0F);
        wb(1'b1, 16'h9C03, 32'h80);
        rdx(16'h9C09, 32'h66);
        rdx(16'h9C00, 32'h77);
        wb(1'b1, 16'h9C03, 32'h00);
    endtask

    task automatic t_misc();
        wb(1'b1, 16'h9C07, 32'hC3);
        wb(1'b1, 16'h9C07, 32'h3C, 4'hE);
        rdx(16'h9C07, 32'hC3);
        chk(32'(ctrl.scratch_reg), 32'hC3);
        wb(1'b1, 16'h9C04, 32'h1F);
        chk(rd, 32'h0);
        rdx(16'h9C04, 32'h1F);
        chk(32'(ctrl.modem_control), 32'h1F);
        wb(1'b1, 16'h9C0C, 32'hBEEF);
        rdx(16'h9C0C, 32'hBEEF);
        wb(1'b1, 16'h9C0C, 32'h1234, 4'h2);
        rdx(16'h9C0C, 32'h12EF);
        chk(32'(ctrl.power_emulation_control), 32'h12EF);
        rdx(16'h9C0A, 32'(pid_lo));
        rdx(16'h9C0B, 32'(pid_hi));
        wb(1'b1, 16'h9C06, 32'hFF);
        rdx(16'h9C06, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        sel = 4'h0;
        wdat = 32'h0;
        status = {8'h00, 8'h01, 8'h60};
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_data();
        t_divisor_access_select();
        t_alias();
        t_misc();
        wrap_up();
    end
endmodule
